// ===== common/scc_pkg.sv
// Constants, register map and carrier types of the switchgear command control block
// What this block does
// (RULE_01) Trip command is the OR of all protection trips enabled in the slot mask.
// (RULE_02) Only the trip manager output drives the trip line; unmasked trips never do.
// (RULE_03) A trip is held at least the hold time; latching is selectable.
// (RULE_04) With latching on, the trip stays active until acknowledged.
// (RULE_05) Latch clears after all sources drop, on ack, ack input, unlatch or empty mask.
// (RULE_06) One external close input and one external open input are accepted.
// (RULE_07) Open wins when open and close requests coincide.
// (RULE_08) Close acts on its rising edge, open acts while its level is high.
// (RULE_09) Bus commands run only with authority remote or local-and-remote.
// (RULE_10) Authority none blocks all, local panel only, remote bus/inputs/internal, both all.
// (RULE_11) Authority never affects protection trips.
// (RULE_12) With sync assigned, close waits for sync within the sync wait limit.
// (RULE_13) Without sync assigned, sync release is always granted.
// (RULE_14) Bypass modes single, permanent, timed; duration bounds single; input may arm it.
// (RULE_15) Manual override replaces the validated position and is flagged.
// (RULE_16) One command at a time; new commands while busy are ignored.
// (RULE_17) A command whose target equals the present position is suppressed.
// (RULE_18) A held panel close gives exactly one close pulse; a new press is needed.
// (RULE_19) Operations are counted; alarm when the count exceeds the limit.
// (RULE_20) Per-phase interrupted current sums; total, phase and hourly alarms.
// (RULE_21) Open capacity kept as percent; maintenance flag at full value.
// (RULE_22) Slow travel alarm when open or close time exceeds its travel limit.
// (RULE_23) Interlocks block their direction; trips and reclose bypass interlocks.
// (RULE_24) Wear curve of ten points interpolated, last point zero, zero above it.
package scc_pkg;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOUR_MS = 3600000;
  localparam int unsigned MOVE_MAX_MS = 2000;
  localparam int unsigned CAPACITY_FULL = 100;
  localparam int unsigned CURVE_POINTS = 10;
  localparam int unsigned TRIP_SLOTS = 8;
  localparam int unsigned FRAC_BITS = 16;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_TRIP_MASK = 8'h08;
  localparam logic [7:0] REG_HOLD_MS = 8'h0C;
  localparam logic [7:0] REG_SYNC_MS = 8'h10;
  localparam logic [7:0] REG_BYPASS_MS = 8'h14;
  localparam logic [7:0] REG_OP_LIMIT = 8'h18;
  localparam logic [7:0] REG_ISUM_LIMIT = 8'h1C;
  localparam logic [7:0] REG_HOUR_LIMIT = 8'h20;
  localparam logic [7:0] REG_TRAVEL = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  localparam logic [7:0] REG_OP_COUNT = 8'h2C;
  localparam logic [7:0] REG_SUM_L1 = 8'h30;
  localparam logic [7:0] REG_SUM_L2 = 8'h34;
  localparam logic [7:0] REG_SUM_L3 = 8'h38;
  localparam logic [7:0] REG_CAPACITY = 8'h3C;
  localparam logic [7:0] REG_CURVE_SEL = 8'h40;
  localparam logic [7:0] REG_CURVE_DATA = 8'h44;
  // Reset values
  localparam logic [31:0] HOLD_RESET = 32'h0000_0064;
  localparam logic [31:0] SYNC_RESET = 32'h0000_03E8;
  localparam logic [31:0] BYPASS_RESET = 32'h0000_EA60;
  localparam logic [31:0] LIMIT_RESET = 32'hFFFF_FFFF;
  localparam logic [31:0] TRAVEL_RESET = 32'h0064_0064;
  localparam logic [3:0] NPTS_RESET = 4'h1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // Command source permission and bypass modes
  typedef enum logic [1:0] {
    SCC_AUTH_NONE = 2'b00, SCC_AUTH_LOCAL = 2'b01, SCC_AUTH_REMOTE = 2'b10,
    SCC_AUTH_BOTH = 2'b11
  } scc_auth_t;
  typedef enum logic [1:0] {
    SCC_BYP_OFF = 2'b00, SCC_BYP_SINGLE = 2'b01, SCC_BYP_PERM = 2'b10, SCC_BYP_TIMED = 2'b11
  } scc_bypass_mode_t;
  typedef enum logic [1:0] {
    SCC_IDLE = 2'b00, SCC_SYNC = 2'b01, SCC_MOVE = 2'b10
  } scc_fsm_t;
  // Control register layout
  typedef struct packed {
    logic override_pos;
    logic override_en;
    logic sync_assigned;
    scc_bypass_mode_t bypass_mode;
    logic latch_en;
    scc_auth_t auth;
  } scc_ctrl_t;
  localparam scc_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b0, SCC_BYP_OFF, 1'b0, SCC_AUTH_BOTH};
  // Command register pulses
  typedef struct packed {
    logic clear_stats;
    logic bypass_arm;
    logic scada_open;
    logic scada_close;
    logic ack;
  } scc_cmd_t;
  // Field pins, synchronised inside
  typedef struct packed {
    logic [TRIP_SLOTS-1:0] prot_trip;
    logic external_close_input;
    logic external_open_input;
    logic sync_ok;
    logic aux_on;
    logic aux_off;
    logic trip_ack_signal;
    logic bypass_signal;
    logic interlock_close;
    logic interlock_open;
    logic panel_close;
    logic panel_open;
    logic reclose;
  } scc_pins_t;
  // Breaker command outputs
  typedef struct packed {
    logic trip;
    logic close_cmd;
    logic open_cmd;
  } scc_drive_t;
  // Status word
  typedef struct packed {
    logic latched;
    logic [2:0] phase_interrupt_alarm;
    logic maintenance_due;
    logic slow_travel_alarm;
    logic hourly_interrupt_alarm;
    logic sum_interrupt_alarm;
    logic operation_alarm;
    logic bypass_active;
    logic position_overridden;
    logic position_closed;
    logic busy;
    logic open_cmd;
    logic close_cmd;
    logic trip;
  } scc_status_t;
endpackage

// ===== hw/scc_switchgear_ctrl.sv
// Switchgear command control: trip manager, command sequencer, wear statistics, AHB-Lite slave
`timescale 1ns/1ps
module scc_switchgear_ctrl #(
  parameter int unsigned TICK_CYCLES = scc_pkg::MS_CYCLES,
  parameter int unsigned HOUR_TICKS = scc_pkg::HOUR_MS,
  parameter int unsigned MOVE_MAX = scc_pkg::MOVE_MAX_MS
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Field side
  input wire scc_pkg::scc_pins_t pins,
  input wire logic [2:0][15:0] phase_current,
  output scc_pkg::scc_drive_t drive,
  output scc_pkg::scc_status_t status,
  output logic [7:0] open_capacity_percent
);
  // Elaboration checks
  if (TICK_CYCLES < 1 || HOUR_TICKS < 1 || MOVE_MAX < 1) begin : g_bad_param
    $error("scc_switchgear_ctrl: counts must be at least one");
  end

  localparam int unsigned NP = scc_pkg::CURVE_POINTS;
  localparam logic [31:0] FULL_FIX = 32'(scc_pkg::CAPACITY_FULL << scc_pkg::FRAC_BITS);
  // Whole module state
  typedef struct packed {
    scc_pkg::scc_pins_t s1, s2, prev;
    logic hreadyout, hresp, dp_wr, tick, latched, trip_raw_d, dir_close, byp_act, slow_alarm;
    logic [31:0] hrdata, hold_ms, sync_ms, bypass_ms, op_limit, isum_limit, hour_limit, travel;
    logic [31:0] tick_cnt, hour_cnt, hold_cnt, tmr, byp_cnt, op_count, wear_acc;
    logic [7:0] dp_addr, capacity;
    scc_pkg::scc_ctrl_t ctrl;
    logic [scc_pkg::TRIP_SLOTS-1:0] trip_mask;
    logic [3:0] curve_sel, curve_npts;
    logic [NP-1:0][31:0] curve;
    scc_pkg::scc_fsm_t fsm;
    logic [2:0][31:0] isum, hsum;
    scc_pkg::scc_drive_t drive;
    scc_pkg::scc_status_t status;
  } scc_state_t;
  scc_state_t r;
  scc_state_t next_r;
  // Allowed operations at a current from the wear curve
  function automatic logic [31:0] scc_allowed(input logic [NP-1:0][31:0] c,
                                              input logic [3:0] n, input logic [15:0] i);
    logic [31:0] res;
    logic [15:0] cp, cn, den;
    logic [31:0] prod;
    res = '0;
    if (i <= c[0][15:0]) begin
      res = (n <= 4'h1) ? 32'h0000_0000 : {16'h0000, c[0][31:16]}; // see (RULE_24)
    end
    for (int k = 1; k < NP; k++) begin
      if (k < int'(n) && i > c[k-1][15:0] && i <= c[k][15:0]) begin
        cp = c[k-1][31:16];
        cn = (k == int'(n) - 1) ? 16'h0000 : c[k][31:16]; // Last point forced to zero
        den = c[k][15:0] - c[k-1][15:0];
        prod = (cp >= cn) ? 32'(cp - cn) * 32'(i - c[k-1][15:0]) : 32'h0000_0000;
        res = (den == 16'h0000) ? {16'h0000, cn} : 32'(cp) - prod / 32'(den); // see (RULE_24)
      end
    end
    return res; // Above the last point stays zero
  endfunction

  // Next state
  always_comb begin
    scc_pkg::scc_cmd_t cmd;
    logic wr, pos_closed, loc_ok, rem_ok, trip_raw, open_req, close_req, reclose_edge;
    logic open_go, close_go, interrupt, start_cmd;
    logic [15:0] imax;
    logic [31:0] cmdw, allowed, inc, lim, rd;
    next_r = r;
    cmdw = '0;
    cmd = '0;
    wr = r.dp_wr;
    pos_closed = 1'b0;
    loc_ok = 1'b0;
    rem_ok = 1'b0;
    trip_raw = 1'b0;
    open_req = 1'b0;
    close_req = 1'b0;
    reclose_edge = 1'b0;
    open_go = 1'b0;
    close_go = 1'b0;
    start_cmd = 1'b0;
    interrupt = 1'b0;
    imax = '0;
    allowed = '0;
    inc = '0;
    lim = '0;
    rd = '0;
    // Input synchronisers and edge history
    next_r.s1 = pins;
    next_r.s2 = r.s1;
    next_r.prev = r.s2;
    // Register writes in the data phase
    if (wr) begin
      case (r.dp_addr)
        scc_pkg::REG_CTRL:
          next_r.ctrl = scc_pkg::scc_ctrl_t'(hwdata[$bits(scc_pkg::scc_ctrl_t)-1:0]);
        scc_pkg::REG_CMD: cmdw = hwdata;
        scc_pkg::REG_TRIP_MASK: next_r.trip_mask = hwdata[scc_pkg::TRIP_SLOTS-1:0];
        scc_pkg::REG_HOLD_MS: next_r.hold_ms = hwdata;
        scc_pkg::REG_SYNC_MS: next_r.sync_ms = hwdata;
        scc_pkg::REG_BYPASS_MS: next_r.bypass_ms = hwdata;
        scc_pkg::REG_OP_LIMIT: next_r.op_limit = hwdata;
        scc_pkg::REG_ISUM_LIMIT: next_r.isum_limit = hwdata;
        scc_pkg::REG_HOUR_LIMIT: next_r.hour_limit = hwdata;
        scc_pkg::REG_TRAVEL: next_r.travel = hwdata;
        scc_pkg::REG_CURVE_SEL: begin
          next_r.curve_sel = hwdata[3:0];
          next_r.curve_npts = (hwdata[7:4] > 4'(NP)) ? 4'(NP) : hwdata[7:4];
        end
        scc_pkg::REG_CURVE_DATA: begin
          if (int'(r.curve_sel) < NP) begin
            next_r.curve[r.curve_sel] = hwdata;
          end
        end
        default: ;
      endcase
    end
    cmd = scc_pkg::scc_cmd_t'(cmdw[$bits(scc_pkg::scc_cmd_t)-1:0]);
    if (cmd.clear_stats) begin
      next_r.slow_alarm = 1'b0; // Cleared first so a slow finish this cycle wins
    end
    // Millisecond and hour tick
    next_r.tick = 1'b0;
    if (r.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      next_r.tick_cnt = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.tick_cnt = r.tick_cnt + 32'h0000_0001;
    end
    if (r.tick) begin
      next_r.hour_cnt = r.hour_cnt + 32'h0000_0001;
      if (r.hour_cnt >= 32'(HOUR_TICKS - 1)) begin
        next_r.hour_cnt = '0;
        next_r.hsum = '0;
      end
    end
    // Position: validated or overridden
    pos_closed = r.ctrl.override_en ? r.ctrl.override_pos
                                    : (r.s2.aux_on & ~r.s2.aux_off); // see (RULE_15)
    // Trip manager
    trip_raw = |(r.s2.prot_trip & r.trip_mask); // see (RULE_01) (RULE_11)
    next_r.trip_raw_d = trip_raw;
    if (r.tick && r.hold_cnt != 32'h0000_0000) begin
      next_r.hold_cnt = r.hold_cnt - 32'h0000_0001;
    end
    if (trip_raw && !r.trip_raw_d) begin
      next_r.hold_cnt = r.hold_ms; // see (RULE_03)
      interrupt = 1'b1;
    end
    // Latch clear needs all sources gone plus a clearing event; set wins
    if (!trip_raw && (cmd.ack || r.s2.trip_ack_signal || !r.ctrl.latch_en ||
                      r.trip_mask == '0)) begin
      next_r.latched = 1'b0; // see (RULE_05)
    end
    if (trip_raw && r.ctrl.latch_en) begin
      next_r.latched = 1'b1; // see (RULE_04)
    end
    // Command source permission
    loc_ok = r.ctrl.auth[0]; // see (RULE_10)
    rem_ok = r.ctrl.auth[1]; // see (RULE_09) (RULE_10)
    reclose_edge = r.s2.reclose & ~r.prev.reclose;
    open_req = (r.s2.panel_open & loc_ok) | (r.s2.external_open_input & rem_ok) |
               (cmd.scada_open & rem_ok); // see (RULE_06) (RULE_08)
    close_req = (r.s2.panel_close & ~r.prev.panel_close & loc_ok) | // see (RULE_18)
                (r.s2.external_close_input & ~r.prev.external_close_input & rem_ok) |
                (cmd.scada_close & rem_ok) | (reclose_edge & rem_ok); // see (RULE_08)
    // Interlocks, bypass and direction check
    open_go = open_req && pos_closed &&
              (!r.s2.interlock_open || r.byp_act); // see (RULE_17) (RULE_23)
    close_go = close_req && !open_req && !pos_closed && // see (RULE_07) (RULE_17)
               (!r.s2.interlock_close || r.byp_act || reclose_edge); // see (RULE_23)
    // Command sequencer, one command at a time
    case (r.fsm)
      scc_pkg::SCC_IDLE: begin
        if (open_go) begin // see (RULE_16)
          next_r.fsm = scc_pkg::SCC_MOVE;
          next_r.dir_close = 1'b0;
          next_r.tmr = '0;
          next_r.drive.open_cmd = 1'b1;
          start_cmd = 1'b1;
          interrupt = 1'b1;
        end else if (close_go && !trip_raw) begin
          next_r.tmr = '0;
          next_r.dir_close = 1'b1;
          start_cmd = 1'b1;
          if (r.ctrl.sync_assigned) begin
            next_r.fsm = scc_pkg::SCC_SYNC; // see (RULE_12)
          end else begin
            next_r.fsm = scc_pkg::SCC_MOVE; // see (RULE_13)
            next_r.drive.close_cmd = 1'b1;
          end
        end
      end
      scc_pkg::SCC_SYNC: begin
        if (r.tick) begin
          next_r.tmr = r.tmr + 32'h0000_0001;
        end
        if (trip_raw) begin
          next_r.fsm = scc_pkg::SCC_IDLE;
        end else if (r.s2.sync_ok) begin
          next_r.fsm = scc_pkg::SCC_MOVE;
          next_r.tmr = '0;
          next_r.drive.close_cmd = 1'b1;
        end else if (r.tmr >= r.sync_ms) begin
          next_r.fsm = scc_pkg::SCC_IDLE; // see (RULE_12)
        end
      end
      scc_pkg::SCC_MOVE: begin
        if (r.tick) begin
          next_r.tmr = r.tmr + 32'h0000_0001;
        end
        lim = r.dir_close ? {16'h0000, r.travel[31:16]} : {16'h0000, r.travel[15:0]};
        if (pos_closed == r.dir_close || r.tmr >= 32'(MOVE_MAX) ||
            (r.dir_close && trip_raw)) begin
          next_r.fsm = scc_pkg::SCC_IDLE;
          next_r.drive.close_cmd = 1'b0;
          next_r.drive.open_cmd = 1'b0;
          if (r.tmr > lim) begin
            next_r.slow_alarm = 1'b1; // see (RULE_22)
          end
        end
      end
      default: begin
        next_r.fsm = scc_pkg::SCC_IDLE;
        next_r.drive.close_cmd = 1'b0;
        next_r.drive.open_cmd = 1'b0;
      end
    endcase
    // Interlock bypass
    if (r.byp_act && r.tick && r.ctrl.bypass_mode != scc_pkg::SCC_BYP_PERM) begin
      next_r.byp_cnt = r.byp_cnt - 32'h0000_0001;
      if (r.byp_cnt <= 32'h0000_0001) begin
        next_r.byp_act = 1'b0; // see (RULE_14)
      end
    end
    if (start_cmd && r.ctrl.bypass_mode == scc_pkg::SCC_BYP_SINGLE) begin
      next_r.byp_act = 1'b0; // see (RULE_14)
    end
    if ((cmd.bypass_arm || (r.s2.bypass_signal && !r.prev.bypass_signal)) &&
        r.ctrl.bypass_mode != scc_pkg::SCC_BYP_OFF) begin
      next_r.byp_act = 1'b1; // see (RULE_14)
      next_r.byp_cnt = r.bypass_ms;
    end
    if (r.ctrl.bypass_mode == scc_pkg::SCC_BYP_OFF) begin
      next_r.byp_act = 1'b0;
    end
    // Wear statistics on every interruption; closes also counted
    imax = phase_current[0];
    for (int p = 1; p < 3; p++) begin
      if (phase_current[p] > imax) begin
        imax = phase_current[p];
      end
    end
    allowed = scc_allowed(r.curve, r.curve_npts, imax);
    inc = (allowed == 32'h0000_0000) ? FULL_FIX : FULL_FIX / allowed;
    if (cmd.clear_stats) begin
      next_r.op_count = '0;
      next_r.isum = '0;
      next_r.hsum = '0;
      next_r.wear_acc = '0;
    end
    if (interrupt || (start_cmd && next_r.dir_close)) begin
      next_r.op_count = next_r.op_count + 32'h0000_0001; // see (RULE_19)
    end
    if (interrupt) begin
      for (int p = 0; p < 3; p++) begin
        next_r.isum[p] = next_r.isum[p] + 32'(phase_current[p]); // see (RULE_20)
        next_r.hsum[p] = next_r.hsum[p] + 32'(phase_current[p]);
      end
      next_r.wear_acc = (next_r.wear_acc + inc > FULL_FIX || next_r.wear_acc + inc < inc)
                        ? FULL_FIX : next_r.wear_acc + inc; // see (RULE_21) (RULE_24)
    end
    next_r.capacity = 8'(r.wear_acc >> scc_pkg::FRAC_BITS);
    // Outputs and status
    next_r.drive.trip = trip_raw || r.hold_cnt != 32'h0000_0000 ||
                        next_r.latched; // see (RULE_02) (RULE_03) (RULE_11)
    next_r.status.trip = next_r.drive.trip;
    next_r.status.close_cmd = next_r.drive.close_cmd;
    next_r.status.open_cmd = next_r.drive.open_cmd;
    next_r.status.busy = next_r.fsm != scc_pkg::SCC_IDLE;
    next_r.status.position_closed = pos_closed;
    next_r.status.position_overridden = r.ctrl.override_en; // see (RULE_15)
    next_r.status.bypass_active = r.byp_act;
    next_r.status.operation_alarm = r.op_count > r.op_limit; // see (RULE_19)
    for (int p = 0; p < 3; p++) begin
      next_r.status.phase_interrupt_alarm[p] = r.isum[p] > r.isum_limit; // see (RULE_20)
    end
    next_r.status.sum_interrupt_alarm = |next_r.status.phase_interrupt_alarm;
    next_r.status.hourly_interrupt_alarm = (r.hsum[0] > r.hour_limit) ||
        (r.hsum[1] > r.hour_limit) || (r.hsum[2] > r.hour_limit); // see (RULE_20)
    next_r.status.slow_travel_alarm = r.slow_alarm;
    next_r.status.maintenance_due = r.capacity >= 8'(scc_pkg::CAPACITY_FULL); // see (RULE_21)
    next_r.status.latched = r.latched;
    // AHB-Lite address phase; zero wait state, always OKAY
    next_r.hreadyout = 1'b1;
    next_r.hresp = 1'b0;
    next_r.dp_wr = 1'b0;
    if (hsel && hready && htrans == scc_pkg::HTRANS_NONSEQ) begin
      next_r.dp_wr = hwrite;
      next_r.dp_addr = haddr[7:0];
      if (!hwrite) begin
        case (haddr[7:0])
          scc_pkg::REG_CTRL: rd = 32'(r.ctrl);
          scc_pkg::REG_TRIP_MASK: rd = 32'(r.trip_mask);
          scc_pkg::REG_HOLD_MS: rd = r.hold_ms;
          scc_pkg::REG_SYNC_MS: rd = r.sync_ms;
          scc_pkg::REG_BYPASS_MS: rd = r.bypass_ms;
          scc_pkg::REG_OP_LIMIT: rd = r.op_limit;
          scc_pkg::REG_ISUM_LIMIT: rd = r.isum_limit;
          scc_pkg::REG_HOUR_LIMIT: rd = r.hour_limit;
          scc_pkg::REG_TRAVEL: rd = r.travel;
          scc_pkg::REG_STATUS: rd = 32'(r.status);
          scc_pkg::REG_OP_COUNT: rd = r.op_count;
          scc_pkg::REG_SUM_L1: rd = r.isum[0];
          scc_pkg::REG_SUM_L2: rd = r.isum[1];
          scc_pkg::REG_SUM_L3: rd = r.isum[2];
          scc_pkg::REG_CAPACITY: rd = 32'(r.capacity);
          scc_pkg::REG_CURVE_SEL: rd = {24'h000000, r.curve_npts, r.curve_sel};
          scc_pkg::REG_CURVE_DATA: rd = (int'(r.curve_sel) < NP) ? r.curve[r.curve_sel] : '0;
          default: rd = '0; // Unmapped and command register read zero
        endcase
        next_r.hrdata = rd;
      end
    end
  end
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.hreadyout <= 1'b1;
      r.ctrl <= scc_pkg::CTRL_RESET;
      r.hold_ms <= scc_pkg::HOLD_RESET;
      r.sync_ms <= scc_pkg::SYNC_RESET;
      r.bypass_ms <= scc_pkg::BYPASS_RESET;
      r.op_limit <= scc_pkg::LIMIT_RESET;
      r.isum_limit <= scc_pkg::LIMIT_RESET;
      r.hour_limit <= scc_pkg::LIMIT_RESET;
      r.travel <= scc_pkg::TRAVEL_RESET;
      r.curve_npts <= scc_pkg::NPTS_RESET;
    end else begin
      r <= next_r;
    end
  end
  // Outputs straight from state
  assign hreadyout = r.hreadyout;
  assign hresp = r.hresp;
  assign hrdata = r.hrdata;
  assign drive = r.drive;
  assign status = r.status;
  assign open_capacity_percent = r.capacity;
endmodule

// ===== bench/scc_props.sv
// Port assertions of the switchgear command control block
`timescale 1ns/1ps
module scc_props (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Watched ports
  input wire scc_pkg::scc_pins_t pins,
  input wire scc_pkg::scc_drive_t drive,
  input wire scc_pkg::scc_status_t status,
  input wire logic [7:0] open_capacity_percent
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Trip cause, hold and latch
  trip_cause_a: assert property ($rose(drive.trip) |-> |$past(pins.prot_trip, 2))
    else $error("trip without cause");
  trip_hold_a: assert property ($rose(drive.trip) |=> drive.trip [*8])
    else $error("trip too short");
  latch_keep_a: assert property (
    status.latched |-> drive.trip || $past(drive.trip)) else $error("latch without trip");
  // Command direction, sequencing and capacity bound
  one_dir_a: assert property (!(drive.open_cmd && drive.close_cmd))
    else $error("open and close together");
  close_tgt_a: assert property (
    $rose(drive.close_cmd) |-> !$past(status.position_closed)) else $error("close when closed");
  open_tgt_a: assert property (
    $rose(drive.open_cmd) |-> $past(status.position_closed)) else $error("open when open");
  cmd_busy_a: assert property (drive.close_cmd || drive.open_cmd |-> status.busy)
    else $error("command while idle");
  cap_max_a: assert property (open_capacity_percent <= 8'h64)
    else $error("capacity above full");
endmodule
bind scc_switchgear_ctrl scc_props u_props (.hclk(hclk), .hresetn(hresetn), .pins(pins),
  .drive(drive), .status(status), .open_capacity_percent(open_capacity_percent));

// ===== bench/scc_breaker_model.sv
// Breaker whose contacts follow the commands after a travel delay
`timescale 1ns/1ps
module scc_breaker_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Commands in, contact state out
  input wire scc_pkg::scc_drive_t drive,
  output logic closed
);
  logic [3:0] travel;
  // Moves only while a command asks for the other position
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      travel <= 4'h0;
      closed <= 1'b0;
    end else if (closed ? (drive.trip || drive.open_cmd) : drive.close_cmd) begin
      travel <= travel + 4'h1;
      if (travel == 4'h5) closed <= !closed;
    end else travel <= 4'h0;
  end
endmodule

// ===== bench/scc_switchgear_ctrl_tb_top.sv
// Self-checking bench of the switchgear command control block
`timescale 1ns/1ps
module scc_switchgear_ctrl_tb_top;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, closed;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [2:0][15:0] ph;
  logic [7:0] cap;
  scc_pkg::scc_pins_t pv, pins;
  scc_pkg::scc_drive_t drive;
  scc_pkg::scc_status_t status;
  int fail_count, n_compared, ncl;
  // One slave, its ready is the bus ready; contacts feed the position pins
  assign hready = hreadyout;
  always_comb begin
    pins = pv;
    pins.aux_on = closed;
    pins.aux_off = !closed;
  end
  always @(posedge drive.close_cmd) ncl++;
  scc_switchgear_ctrl #(.TICK_CYCLES(4), .HOUR_TICKS(20), .MOVE_MAX(10)) u_dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pins(pins), .phase_current(ph), .drive(drive), .status(status),
    .open_capacity_percent(cap));
  scc_breaker_model u_brk (.hclk(hclk), .hresetn(hresetn), .drive(drive), .closed(closed));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  // Single word transfer; a read is compared with d
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= scc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    chk(hresp, 1'b0);
    if (!w) chk(hrdata, d);
  endtask
  task automatic summarize();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, pv} = '0;
    hsize = 3'h2;
    ph = {3{16'h0020}};
    hresetn = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    wc(1);
    bus(1'b0, scc_pkg::REG_CTRL, 32'h3);
    bus(1'b0, scc_pkg::REG_HOLD_MS, scc_pkg::HOLD_RESET);
    bus(1'b0, 8'h80, 32'h0);
    // Held panel close, then a press while closed
    pv.panel_close <= 1'b1;
    wc(40);
    chk(status.position_closed, 1'b1);
    pv.panel_close <= 1'b0;
    wc(4);
    pv.panel_close <= 1'b1;
    wc(30);
    chk(ncl, 1);
    pv.panel_close <= 1'b0;
    // Latched trip with no authority, unassigned slot first
    bus(1'b1, scc_pkg::REG_CTRL, 32'h4);
    bus(1'b1, scc_pkg::REG_TRIP_MASK, 32'h4);
    pv.prot_trip <= 8'h01;
    wc(20);
    chk(drive.trip, 1'b0);
    pv.prot_trip <= 8'h05;
    wc(4);
    chk(drive.trip, 1'b1);
    pv.prot_trip <= 8'h00;
    wc(500);
    chk(drive.trip, 1'b1);
    chk({status.maintenance_due, cap}, 32'h164);
    bus(1'b1, scc_pkg::REG_CMD, 32'h1);
    wc(3);
    chk(drive.trip, 1'b0);
    // Bus close under local, then remote authority
    bus(1'b1, scc_pkg::REG_CTRL, 32'h1);
    bus(1'b1, scc_pkg::REG_CMD, 32'h2);
    wc(30);
    chk(ncl, 1);
    bus(1'b1, scc_pkg::REG_CTRL, 32'h2);
    bus(1'b1, scc_pkg::REG_CMD, 32'h2);
    wc(30);
    chk(ncl, 2);
    // External open and close together, close held on
    pv.external_open_input <= 1'b1;
    pv.external_close_input <= 1'b1;
    wc(40);
    chk(status.position_closed, 1'b0);
    pv.external_open_input <= 1'b0;
    wc(40);
    chk(ncl, 2);
    pv.external_close_input <= 1'b0;
    // Close waits for the sync signal
    bus(1'b1, scc_pkg::REG_CTRL, 32'h22);
    bus(1'b1, scc_pkg::REG_CMD, 32'h2);
    wc(20);
    chk(ncl, 2);
    pv.sync_ok <= 1'b1;
    wc(30);
    chk(ncl, 3);
    bus(1'b1, scc_pkg::REG_OP_LIMIT, 32'h2);
    wc(3);
    chk(status.operation_alarm, 1'b1);
    // Bus open with zero travel limits, then current sums against a low limit
    bus(1'b1, scc_pkg::REG_TRAVEL, 32'h0);
    bus(1'b1, scc_pkg::REG_CMD, 32'h4);
    wc(4);
    chk({drive.open_cmd, status.busy}, 32'h3);
    wc(30);
    chk(status.slow_travel_alarm, 1'b1);
    bus(1'b0, scc_pkg::REG_SUM_L1, 32'h60);
    bus(1'b1, scc_pkg::REG_ISUM_LIMIT, 32'h5F);
    wc(3);
    chk({status.sum_interrupt_alarm, status.phase_interrupt_alarm}, 32'hF);
    // Close held back by its interlock, then let through once by a single bypass
    pv.interlock_close <= 1'b1;
    bus(1'b1, scc_pkg::REG_CTRL, 32'hA);
    bus(1'b1, scc_pkg::REG_CMD, 32'h2);
    wc(30);
    chk(ncl, 3);
    bus(1'b1, scc_pkg::REG_CMD, 32'h8);
    bus(1'b1, scc_pkg::REG_CMD, 32'h2);
    wc(30);
    chk(ncl, 4);
    chk(status.bypass_active, 1'b0);
    // Manual position shows open while the contacts are closed
    bus(1'b1, scc_pkg::REG_CTRL, 32'h4A);
    wc(3);
    chk({status.position_overridden, status.position_closed}, 32'h2);
    summarize();
  end
endmodule
